/* File: hlc_cfg.svh */
// Register indices, field positions, reset values and codes of the HDLC link controller.
// Byte address of a register on the APB bus is four times its index.
`ifndef HLC_CFG_SVH
`define HLC_CFG_SVH

`define HLC_RX_MAP 9'h010
`define HLC_RX_SUP 9'h011
`define HLC_RX_BUF 9'h087
`define HLC_RX_LAT 9'h094
`define HLC_RX_MSK 9'h0A4
`define HLC_RX_LIVE 9'h0B4
`define HLC_RX_AVAIL 9'h0B5
`define HLC_RX_DATA 9'h0B6
`define HLC_TX_CTL1 9'h110
`define HLC_TX_SUP 9'h111
`define HLC_TX_CTL2 9'h113
`define HLC_TX_BUF 9'h187
`define HLC_TX_LAT 9'h191
`define HLC_TX_MSK 9'h1A1
`define HLC_TX_LIVE 9'h1B1
`define HLC_TX_SPACE 9'h1B3
`define HLC_TX_DATA 9'h1B4

`define HLC_CTL_RST 8'h00
`define HLC_RX_MARK_RST 7'h30
`define HLC_TX_MARK_RST 7'h10
`define HLC_BUF_FLUSH 7
`define HLC_TX1_EOM 2
`define HLC_RST_BIT 5
`define HLC_DEPTH 7'h40
`define HLC_SA_FIRST 3'h3
`define HLC_FLAG 8'h7E
`define HLC_ABORT 8'hFF
`define HLC_CRC_INIT 16'hFFFF
`define HLC_CRC_POLY 16'h8408
`define HLC_CRC_GOOD 16'hF0B8

`endif

/* File: hlc_pkg.sv */
// Types shared by the HDLC link controller modules.
// Carrier codes sit in bits 6:5 of the mapping registers.
package hlc_pkg;
	typedef enum logic [1:0] {HLC_CAR_SLOT, HLC_CAR_SA, HLC_CAR_FDL} hlc_carrier_e;
	typedef enum logic [2:0] {HLC_TX_IDLE, HLC_TX_DATA, HLC_TX_FCS_LO, HLC_TX_FCS_HI, HLC_TX_ABORT} hlc_tx_e;
endpackage : hlc_pkg

/* File: hlc_mem_if.sv */
// Port bundle between the controller and one byte buffer memory.
// Words are nine bits: a byte plus a message-end tag.
`timescale 1ns/1ps
interface hlc_mem_if;
	logic we;
	logic [5:0] waddr;
	logic [5:0] raddr;
	logic [8:0] wdata;
	logic [8:0] rdata;
	modport ctl(output we, waddr, raddr, wdata, input rdata);
	modport mem(input we, waddr, raddr, wdata, output rdata);
endinterface : hlc_mem_if

/* File: hlc_mem.sv */
// 64 x 9 buffer memory with registered read data.
// Assumes one clock; a write to the address being read is passed straight through.
`timescale 1ns/1ps
module hlc_mem (
	// Clock
	input wire logic pclk,
	// Access port
	hlc_mem_if.mem m
);
	logic [8:0] store [0:63];

	// Write port
	always_ff @(posedge pclk) begin
		if (m.we) begin
			store[m.waddr] <= m.wdata;
		end
	end

	// Read port, bypassed so a fresh byte is never missed
	always_ff @(posedge pclk) begin
		m.rdata <= (m.we && m.waddr == m.raddr) ? m.wdata : store[m.raddr];
	end
endmodule : hlc_mem

/* File: hlc_crc16.sv */
// One bit step of the reflected 16-bit frame check sequence.
// Pure logic; the caller holds the running value.
`timescale 1ns/1ps
`include "hlc_cfg.svh"
module hlc_crc16 (
	// Running value and next bit
	input wire logic [15:0] crc_in,
	input wire logic bit_in,
	// Updated value
	output logic [15:0] crc_out
);
	// Shift right, fold in polynomial on feedback
	assign crc_out = {1'b0, crc_in[15:1]} ^ ((crc_in[0] ^ bit_in) ? `HLC_CRC_POLY : 16'h0000);
endmodule : hlc_crc16

/* File: hlc_link_ctrl.sv */
// HDLC link controller: APB registers, 64-byte buffers each way, bit-level framing.
// Assumes link_strobe pulses once per framer bit, at least four pclk cycles apart.
//
// Operation
// RULE_01 - Carrier is one time slot, E1 Sa4 to Sa8 bits, or T1 data link.
// RULE_02 - In slot mode only unsuppressed bit positions carry data; others ignored or unused.
// RULE_03 - Each direction owns its own 64-byte first-in first-out buffer.
// RULE_04 - Transmit adds flags, checksum, aborts; receive detects flags, aborts, checks checksum.
// RULE_05 - Zero inserted after five ones on transmit, removed on receive; flags align bytes.
// RULE_06 - Receive and transmit buffer control registers set the watermark levels.
// RULE_07 - Receive live bit 1 is high while receive fill exceeds the high watermark.
// RULE_08 - Transmit low-mark live bit is high while fill below mark; may interrupt.
// RULE_09 - Receive overrun drops the packet, empties the buffer, flags live and latched bit 5.
// RULE_10 - Low seven bits of bytes-available give readable bytes up to message end.
// RULE_11 - Bytes-available top bit is 1 when counted bytes do not finish a message.
// RULE_12 - Host checks status for message end after reading the counted bytes.
// RULE_13 - Latched bits hold until written with 1; zeros and live bits ignore writes.
// RULE_14 - A cleared latched bit sets again only on a new event, not persistence.
// RULE_15 - Live status bits follow the present condition without memory.
// RULE_16 - Host reads status then writes ones only where it wants bits cleared.
// RULE_17 - Every latched event has its own interrupt mask bit.
// RULE_18 - Unmasked event drives interrupt low; released once host reads the causing bit.
// RULE_19 - Transmit space register shows live free bytes in the transmit buffer.
// RULE_20 - Transmit space value is held steady through the whole read cycle.
// RULE_21 - Flag pattern 01111110 and 16-bit frame check sequence are used.
`timescale 1ns/1ps
`include "hlc_cfg.svh"
module hlc_link_ctrl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [10:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Framer bit position, shared by both directions, and the receive bit
	input wire logic link_strobe,
	input wire logic [4:0] link_slot,
	input wire logic [2:0] link_bit_pos,
	input wire logic link_sa_frame,
	input wire logic link_fdl,
	input wire logic link_rx_bit,
	// Transmit bit toward the framer
	output logic link_tx_bit,
	output logic link_tx_used,
	// Interrupt
	output logic interrupt_out_n
);
	logic [7:0] rx_map, rx_sup, tx_ctl1, tx_sup, tx_ctl2;
	logic [6:0] rx_mark, tx_mark;
	logic [7:0] rx_lat, rx_msk, rx_ack, tx_lat, tx_msk, tx_ack;
	logic [6:0] rx_wr, rx_rd, tx_wr, tx_rd;
	logic [63:0] rx_tag;
	logic rx_push, rx_tag_end, rx_high_d, tx_low_d;
	logic [7:0] rx_push_byte;
	logic ev_start, ev_end, ev_abort, ev_crc, ev_ovr, ev_undr, ev_tend;
	logic [7:0] rd_val;
	logic rd_ok;

	hlc_mem_if rxm();
	hlc_mem_if txm();
	hlc_mem u_rx_mem (.pclk(pclk), .m(rxm.mem));
	hlc_mem u_tx_mem (.pclk(pclk), .m(txm.mem));

	// Carrier and bit-position selection, same for both directions
	function automatic logic hlc_bit_used(input logic [7:0] map, input logic [7:0] sup, input logic [4:0] slot,
		input logic [2:0] pos, input logic sa_frame, input logic fdl);
		logic r;
		r = 1'b0;
		case (hlc_pkg::hlc_carrier_e'(map[6:5]))
			hlc_pkg::HLC_CAR_SLOT: r = (slot == map[4:0]) && !sup[pos]; // RULE_01 RULE_02
			hlc_pkg::HLC_CAR_SA: r = (slot == 5'h00) && sa_frame && (pos >= `HLC_SA_FIRST) && !sup[pos]; // RULE_01
			hlc_pkg::HLC_CAR_FDL: r = fdl; // RULE_01
			default: r = 1'b0;
		endcase
		return r;
	endfunction : hlc_bit_used

	// Latched status next value; a new event wins over a host clear
	function automatic logic [7:0] hlc_latch(input logic [7:0] lat, input logic [7:0] clr, input logic [7:0] ev);
		return (lat & ~clr) | ev;
	endfunction : hlc_latch

	// Bytes readable before the first message end, top bit for an open message
	function automatic logic [7:0] hlc_avail(input logic [63:0] tag, input logic [5:0] rd, input logic [6:0] fill);
		logic [7:0] r;
		logic found;
		logic [5:0] p;
		r = {1'b1, fill}; // RULE_11
		found = 1'b0;
		for (int i = 0; i < 64; i++) begin
			p = rd + 6'(i);
			if (!found && 7'(i) < fill && tag[p]) begin
				found = 1'b1;
				r = {1'b0, 7'(i + 1)}; // RULE_10
			end
		end
		if (fill == 7'h00) begin
			r = 8'h00;
		end
		return r;
	endfunction : hlc_avail

	wire setup = psel & ~penable;
	wire access = psel & penable & pready;
	wire [8:0] idx = paddr[10:2];
	wire wr = access & pwrite;
	wire rd = access & ~pwrite;
	wire rx_sel = link_strobe & hlc_bit_used(rx_map, rx_sup, link_slot, link_bit_pos, link_sa_frame, link_fdl);
	wire tx_sel = link_strobe & hlc_bit_used(tx_ctl2, tx_sup, link_slot, link_bit_pos, link_sa_frame, link_fdl);

	// Buffer fill levels and derived live conditions
	wire [6:0] rx_fill = rx_wr - rx_rd;
	wire [6:0] tx_fill = tx_wr - tx_rd;
	wire [6:0] tx_space = `HLC_DEPTH - tx_fill; // RULE_19
	wire rx_high = rx_fill > rx_mark; // RULE_07
	wire tx_low = tx_fill < tx_mark; // RULE_08
	wire rx_full = rx_fill == `HLC_DEPTH;
	wire rx_ovr_now = rx_push & rx_full;
	wire rx_pop = rd && idx == `HLC_RX_DATA && rx_fill != 7'h00;
	wire tx_push = wr && idx == `HLC_TX_DATA && tx_fill != `HLC_DEPTH;
	wire rx_flush = wr && idx == `HLC_RX_BUF && pwdata[`HLC_BUF_FLUSH];
	wire tx_flush = wr && idx == `HLC_TX_BUF && pwdata[`HLC_BUF_FLUSH];
	logic tx_pop;
	logic rx_drop;
	wire [7:0] rx_live = {2'b00, rx_drop, 3'b000, rx_high, 1'b0}; // RULE_15 RULE_09
	wire [7:0] tx_live = {7'h00, tx_low}; // RULE_15
	wire [7:0] rx_ev = {2'b00, ev_ovr, ev_crc, ev_abort, ev_end, rx_high & ~rx_high_d, ev_start};
	wire [7:0] tx_ev = {5'h00, ev_tend, ev_undr, tx_low & ~tx_low_d};

	// Memory ports; read address looks one pop ahead
	assign rxm.we = rx_push & ~rx_full;
	assign rxm.waddr = rx_wr[5:0];
	assign rxm.wdata = {1'b0, rx_push_byte};
	assign rxm.raddr = rx_rd[5:0] + {5'h00, rx_pop};
	assign txm.we = tx_push;
	assign txm.waddr = tx_wr[5:0];
	assign txm.wdata = {tx_ctl1[`HLC_TX1_EOM], pwdata[7:0]};
	assign txm.raddr = tx_rd[5:0] + {5'h00, tx_pop};

	// Read mux; live values are sampled at setup and held through access
	always_comb begin
		rd_ok = 1'b1;
		case (idx)
			`HLC_RX_MAP: rd_val = rx_map;
			`HLC_RX_SUP: rd_val = rx_sup;
			`HLC_RX_BUF: rd_val = {1'b0, rx_mark};
			`HLC_RX_LAT: rd_val = rx_lat;
			`HLC_RX_MSK: rd_val = rx_msk;
			`HLC_RX_LIVE: rd_val = rx_live;
			`HLC_RX_AVAIL: rd_val = hlc_avail(rx_tag, rx_rd[5:0], rx_fill);
			`HLC_RX_DATA: rd_val = (rx_fill != 7'h00) ? rxm.rdata[7:0] : 8'h00;
			`HLC_TX_CTL1: rd_val = tx_ctl1;
			`HLC_TX_SUP: rd_val = tx_sup;
			`HLC_TX_CTL2: rd_val = tx_ctl2;
			`HLC_TX_BUF: rd_val = {1'b0, tx_mark};
			`HLC_TX_LAT: rd_val = tx_lat;
			`HLC_TX_MSK: rd_val = tx_msk;
			`HLC_TX_LIVE: rd_val = tx_live;
			`HLC_TX_SPACE: rd_val = {1'b0, tx_space};
			`HLC_TX_DATA: rd_val = 8'h00;
			default: begin
				rd_val = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	// APB answer: one wait-free access cycle after every setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (setup) begin
			pready <= 1'b1;
			pslverr <= ~rd_ok;
			prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_val}; // RULE_20
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Control registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_map <= `HLC_CTL_RST;
			rx_sup <= `HLC_CTL_RST;
			tx_ctl1 <= `HLC_CTL_RST;
			tx_sup <= `HLC_CTL_RST;
			tx_ctl2 <= `HLC_CTL_RST;
			rx_mark <= `HLC_RX_MARK_RST;
			tx_mark <= `HLC_TX_MARK_RST;
			rx_msk <= `HLC_CTL_RST;
			tx_msk <= `HLC_CTL_RST;
		end else begin
			if (wr) begin
				case (idx)
					`HLC_RX_MAP: rx_map <= pwdata[7:0];
					`HLC_RX_SUP: rx_sup <= pwdata[7:0];
					`HLC_RX_BUF: rx_mark <= pwdata[6:0]; // RULE_06
					`HLC_RX_MSK: rx_msk <= pwdata[7:0]; // RULE_17
					`HLC_TX_CTL1: tx_ctl1 <= pwdata[7:0];
					`HLC_TX_SUP: tx_sup <= pwdata[7:0];
					`HLC_TX_CTL2: tx_ctl2 <= pwdata[7:0];
					`HLC_TX_BUF: tx_mark <= pwdata[6:0]; // RULE_06
					`HLC_TX_MSK: tx_msk <= pwdata[7:0]; // RULE_17
					default: ;
				endcase
			end
			if (tx_push) begin
				tx_ctl1[`HLC_TX1_EOM] <= 1'b0; // End mark rides on one byte only
			end
		end
	end

	// Latched status, read acknowledgement and interrupt pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_lat <= 8'h00;
			tx_lat <= 8'h00;
			rx_ack <= 8'h00;
			tx_ack <= 8'h00;
			rx_high_d <= 1'b0;
			tx_low_d <= 1'b0;
			interrupt_out_n <= 1'b1;
		end else begin
			rx_high_d <= rx_high; // RULE_14
			tx_low_d <= tx_low; // RULE_14
			rx_lat <= hlc_latch(rx_lat, (wr && idx == `HLC_RX_LAT) ? pwdata[7:0] : 8'h00, rx_ev); // RULE_13
			tx_lat <= hlc_latch(tx_lat, (wr && idx == `HLC_TX_LAT) ? pwdata[7:0] : 8'h00, tx_ev); // RULE_13
			rx_ack <= (rx_ack | ((rd && idx == `HLC_RX_LAT) ? rx_lat : 8'h00)) & ~rx_ev; // RULE_18
			tx_ack <= (tx_ack | ((rd && idx == `HLC_TX_LAT) ? tx_lat : 8'h00)) & ~tx_ev; // RULE_18
			interrupt_out_n <= ~(|(rx_lat & rx_msk & ~rx_ack) | |(tx_lat & tx_msk & ~tx_ack)); // RULE_18 RULE_08
		end
	end

	// Receive buffer pointers and message-end tags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_wr <= 7'h00;
			rx_rd <= 7'h00;
			rx_tag <= 64'h0000000000000000;
			ev_ovr <= 1'b0;
		end else begin
			ev_ovr <= rx_ovr_now; // RULE_09
			if (rx_flush || rx_ovr_now) begin
				rx_wr <= 7'h00; // RULE_09
				rx_rd <= 7'h00;
			end else begin
				if (rx_push) begin
					rx_wr <= rx_wr + 7'h01; // RULE_03
					rx_tag[rx_wr[5:0]] <= 1'b0;
				end
				if (rx_tag_end) begin
					rx_tag[rx_wr[5:0] - 6'h01] <= 1'b1;
				end
				if (rx_pop) begin
					rx_rd <= rx_rd + 7'h01;
				end
			end
		end
	end

	// Receive framing: destuffing, flags, aborts, byte assembly, checksum
	logic [2:0] r_ones, r_dv, r_bits;
	logic [6:0] r_dq;
	logic [7:0] r_byte, r_h0, r_h1;
	logic [1:0] r_hcnt;
	logic [15:0] r_crc, r_crc_nx;
	logic r_in_frame, r_has;
	hlc_crc16 u_rx_crc (.crc_in(r_crc), .bit_in(r_dq[6]), .crc_out(r_crc_nx));
	wire r_stuff = ~link_rx_bit && r_ones == 3'h5;
	wire r_flag = ~link_rx_bit && r_ones == 3'h6;
	wire r_abort = link_rx_bit && r_ones == 3'h6;
	wire r_commit = r_dv == 3'h7 && r_in_frame && !rx_drop;
	wire [7:0] r_next = {r_dq[6], r_byte[7:1]};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{r_ones, r_dv, r_bits, r_dq, r_byte, r_h0, r_h1, r_hcnt} <= '0;
			{r_in_frame, r_has, rx_drop, rx_push, rx_tag_end} <= '0;
			{ev_start, ev_end, ev_abort, ev_crc} <= '0;
			rx_push_byte <= 8'h00;
			r_crc <= `HLC_CRC_INIT;
		end else begin
			{rx_push, rx_tag_end, ev_start, ev_end, ev_abort, ev_crc} <= '0;
			if (rx_flush || rx_ovr_now) begin
				r_in_frame <= 1'b0; // Rest of the packet is dropped until a flag
				rx_drop <= rx_ovr_now; // RULE_09
				r_dv <= 3'h0;
			end else if (rx_sel) begin
				r_ones <= link_rx_bit ? ((r_ones == 3'h7) ? 3'h7 : r_ones + 3'h1) : 3'h0;
				if (r_flag) begin
					if (r_in_frame && r_has && !rx_drop) begin
						rx_tag_end <= 1'b1;
						ev_end <= 1'b1;
						ev_crc <= r_hcnt != 2'h2 || r_bits != 3'h0 || r_crc != `HLC_CRC_GOOD; // RULE_04 RULE_21
					end
					{r_in_frame, rx_drop, r_dv, r_bits, r_hcnt, r_has} <= {1'b1, 1'b0, 3'h0, 3'h0, 2'h0, 1'b0}; // RULE_05
					r_crc <= `HLC_CRC_INIT;
				end else if (r_abort) begin
					ev_abort <= r_in_frame && !rx_drop && (r_has || r_hcnt != 2'h0); // RULE_04
					rx_tag_end <= r_in_frame && !rx_drop && r_has;
					r_in_frame <= 1'b0;
					r_dv <= 3'h0;
				end else if (!r_stuff) begin
					r_dq <= {r_dq[5:0], link_rx_bit}; // RULE_05
					if (r_dv != 3'h7) begin
						r_dv <= r_dv + 3'h1;
					end
					if (r_commit) begin
						r_bits <= r_bits + 3'h1;
						r_crc <= r_crc_nx;
						r_byte <= r_next;
						if (r_bits == 3'h7) begin
							case (r_hcnt)
								2'h0: r_h0 <= r_next;
								2'h1: r_h1 <= r_next;
								default: begin
									rx_push <= 1'b1; // Last two bytes held back as checksum
									rx_push_byte <= r_h0;
									ev_start <= !r_has;
									r_has <= 1'b1;
									r_h0 <= r_h1;
									r_h1 <= r_next;
								end
							endcase
							if (r_hcnt != 2'h2) begin
								r_hcnt <= r_hcnt + 2'h1;
							end
						end
					end
				end
			end
		end
	end

	// Transmit buffer pointers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wr <= 7'h00;
			tx_rd <= 7'h00;
		end else if (tx_flush) begin
			tx_wr <= 7'h00;
			tx_rd <= 7'h00;
		end else begin
			if (tx_push) begin
				tx_wr <= tx_wr + 7'h01; // RULE_03
			end
			if (tx_pop) begin
				tx_rd <= tx_rd + 7'h01;
			end
		end
	end

	// Transmit framing: flags, data, checksum, abort on underrun, zero stuffing
	hlc_pkg::hlc_tx_e t_st;
	logic [7:0] t_sh;
	logic [2:0] t_left, t_ones;
	logic [15:0] t_crc, t_crc_nx;
	logic t_stuff, t_eom;
	hlc_crc16 u_tx_crc (.crc_in(t_crc), .bit_in(t_sh[0]), .crc_out(t_crc_nx));
	wire t_have = tx_fill != 7'h00 && !tx_pop;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t_st <= hlc_pkg::HLC_TX_IDLE;
			t_sh <= `HLC_FLAG;
			{t_left, t_ones, t_stuff, t_eom, tx_pop, ev_undr, ev_tend} <= '0;
			t_left <= 3'h7;
			t_crc <= `HLC_CRC_INIT;
			link_tx_bit <= 1'b1;
			link_tx_used <= 1'b0;
		end else begin
			{tx_pop, ev_undr, ev_tend} <= '0;
			link_tx_used <= tx_sel; // RULE_02
			if (tx_sel && (t_stuff || t_left == 3'h7) && t_ones == 3'h5) begin // Also before a closing flag
				link_tx_bit <= 1'b0; // RULE_05
				t_ones <= 3'h0;
			end else if (tx_sel) begin
				link_tx_bit <= t_sh[0];
				t_ones <= t_sh[0] ? ((t_ones == 3'h7) ? 3'h7 : t_ones + 3'h1) : 3'h0;
				t_sh <= {1'b0, t_sh[7:1]};
				t_left <= t_left - 3'h1;
				if (t_st == hlc_pkg::HLC_TX_DATA) begin
					t_crc <= t_crc_nx;
				end
				if (t_left == 3'h0) begin
					t_left <= 3'h7;
					t_stuff <= 1'b1;
					case (t_st)
						hlc_pkg::HLC_TX_IDLE: begin
							if (t_have) begin
								t_sh <= txm.rdata[7:0];
								t_eom <= txm.rdata[8];
								tx_pop <= 1'b1;
								t_crc <= `HLC_CRC_INIT;
								t_st <= hlc_pkg::HLC_TX_DATA;
							end else begin
								t_sh <= `HLC_FLAG; // RULE_04 RULE_21
								t_stuff <= 1'b0;
							end
						end
						hlc_pkg::HLC_TX_DATA: begin
							if (t_eom) begin
								t_sh <= ~t_crc_nx[7:0]; // RULE_04
								t_st <= hlc_pkg::HLC_TX_FCS_LO;
							end else if (t_have) begin
								t_sh <= txm.rdata[7:0];
								t_eom <= txm.rdata[8];
								tx_pop <= 1'b1;
							end else begin
								t_sh <= `HLC_ABORT; // RULE_04
								t_stuff <= 1'b0;
								ev_undr <= 1'b1;
								t_st <= hlc_pkg::HLC_TX_ABORT;
							end
						end
						hlc_pkg::HLC_TX_FCS_LO: begin
							t_sh <= ~t_crc[15:8];
							t_st <= hlc_pkg::HLC_TX_FCS_HI;
						end
						hlc_pkg::HLC_TX_FCS_HI: begin
							t_sh <= `HLC_FLAG; // RULE_04
							t_stuff <= 1'b0;
							ev_tend <= 1'b1;
							t_st <= hlc_pkg::HLC_TX_IDLE;
						end
						default: begin
							t_sh <= `HLC_FLAG;
							t_stuff <= 1'b0;
							t_st <= hlc_pkg::HLC_TX_IDLE;
						end
					endcase
				end
			end
		end
	end
endmodule : hlc_link_ctrl

/* File: hlc_link_ctrl_sva.sv */
// Port-level assertions for the HDLC link controller.
// Bound to hlc_link_ctrl; single pclk domain, presetn async active low.
`timescale 1ns/1ps
`include "hlc_cfg.svh"
module hlc_link_ctrl_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [10:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Framer side
	input wire logic link_strobe,
	input wire logic [4:0] link_slot,
	input wire logic [2:0] link_bit_pos,
	input wire logic link_sa_frame,
	input wire logic link_fdl,
	input wire logic link_rx_bit,
	input wire logic link_tx_bit,
	input wire logic link_tx_used,
	// Interrupt
	input wire logic interrupt_out_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [8:0] idx;
	logic mapped;
	logic lat_acc;
	// Word index decode; lat_acc marks an access to a latched register
	assign idx = paddr[10:2];
	assign mapped = idx inside {`HLC_RX_MAP, `HLC_RX_SUP, `HLC_RX_BUF, `HLC_RX_LAT, `HLC_RX_MSK, `HLC_RX_LIVE,
		`HLC_RX_AVAIL, `HLC_RX_DATA, `HLC_TX_CTL1, `HLC_TX_SUP, `HLC_TX_CTL2, `HLC_TX_BUF, `HLC_TX_LAT,
		`HLC_TX_MSK, `HLC_TX_LIVE, `HLC_TX_SPACE, `HLC_TX_DATA};
	assign lat_acc = psel && penable && pready && (idx == `HLC_RX_LAT || idx == `HLC_TX_LAT);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	chk_ready_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held over one cycle");
	chk_err_unmapped: assert property (s_done |-> pslverr == !mapped) else $error("error flag wrong");
	chk_err_read_zero: assert property (s_done ##0 (!mapped && !pwrite) |-> prdata == 32'h0) else $error("bad read");
	chk_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h0) else $error("read data upper bits set");
	chk_used_strobe: assert property (link_tx_used |-> $past(link_strobe)) else $error("used without strobe");
	chk_txbit_hold: assert property (!$stable(link_tx_bit) |-> $past(link_strobe)) else $error("tx bit moved");
	chk_irq_release: assert property ($rose(interrupt_out_n) |-> $past(lat_acc, 1) || $past(lat_acc, 2))
		else $error("interrupt released without latched access");
endmodule : hlc_link_ctrl_sva

bind hlc_link_ctrl hlc_link_ctrl_sva chk_u (.*);

/* File: hlc_framer_model.sv */
// Framer model: bit strobes and a one-bit loopback of transmit to receive.
// Every strobe is slot 0 of an Sa frame on the data link, so each carrier sees it; the Sa carrier only at positions 3 to 7.
`timescale 1ns/1ps
module hlc_framer_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench control
	input wire logic run,
	input wire logic slow,
	// Framer side
	output logic link_strobe,
	output logic [4:0] link_slot,
	output logic [2:0] link_bit_pos,
	output logic link_sa_frame,
	output logic link_fdl,
	output logic link_rx_bit,
	input wire logic link_tx_bit,
	input wire logic link_tx_used
);
	logic [2:0] gap;
	logic loop_bit;
	// Off-strobe the line shows the inverse, so a mistimed sample is caught
	assign link_slot = 5'h00;
	assign link_sa_frame = 1'b1;
	assign link_fdl = 1'b1;
	assign link_rx_bit = link_strobe ? loop_bit : ~loop_bit;
	// Strobes four or six cycles apart; stopped while run is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap <= 3'h0;
			link_strobe <= 1'b0;
			link_bit_pos <= 3'h0;
		end else if (gap != 3'h0) begin
			gap <= gap - 3'h1;
			link_strobe <= 1'b0;
		end else begin
			link_strobe <= run;
			gap <= run ? (slow ? 3'h5 : 3'h3) : 3'h0;
			link_bit_pos <= link_bit_pos + {2'h0, run}; // Each new strobe gets the next position
		end
	end
	// Loopback keeps the last used transmit bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_bit <= 1'b1;
		end else if (link_tx_used) begin
			loop_bit <= link_tx_bit;
		end
	end
endmodule : hlc_framer_model

/* File: tb_hlc_link_ctrl.sv */
// Self-checking bench for hlc_link_ctrl over APB, with a looped-back framer model.
// Expectations are queued per access and checked when pready appears.
`timescale 1ns/1ps
`include "hlc_cfg.svh"
module tb_hlc_link_ctrl;
	typedef struct packed {logic [7:0] ex; logic [7:0] mk; logic er;} hlc_note_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run, slow;
	logic [10:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic link_strobe, link_sa_frame, link_fdl, link_rx_bit, link_tx_bit, link_tx_used, interrupt_out_n;
	logic [4:0] link_slot;
	logic [2:0] link_bit_pos;
	logic [7:0] rd;
	logic [7:0] frame [3];
	hlc_note_s notes [$];
	hlc_note_s note;
	int error_cnt = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	localparam logic [8:0] rst_idx [9] = '{`HLC_RX_BUF, `HLC_TX_BUF, `HLC_RX_MSK, `HLC_TX_MSK, `HLC_TX_SPACE,
		`HLC_RX_AVAIL, `HLC_TX_LIVE, `HLC_RX_LIVE, 9'h000};
	localparam logic [7:0] rst_val [9] = '{8'h30, 8'h10, 8'h00, 8'h00, 8'h40, 8'h00, 8'h01, 8'h00, 8'h00};
	localparam logic [7:0] rst_msk [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h22, 8'h00};
	localparam logic [7:0] maps [3] = '{8'h00, 8'h20, 8'h40};

	hlc_link_ctrl dut_u (.*);
	hlc_framer_model frm_u (.*);

	// Clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	function automatic logic [7:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : xs

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [8:0] idx, input logic [7:0] wd, input logic [7:0] ex,
		input logic [7:0] mk);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		notes.push_back('{ex, mk, idx == 9'h000});
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, 0, 1);
		end
		rd = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rc(input logic [8:0] idx, input logic [7:0] ex, input logic [7:0] mk);
		apb(1'b0, idx, 8'h00, ex, mk);
	endtask : rc

	task automatic wr(input logic [8:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 8'h00, 8'h00);
	endtask : wr

	// Poll a register until the masked value equals lim; open-message counts carry bit 7
	task automatic poll(input logic [8:0] idx, input logic [7:0] mk, input logic [7:0] lim);
		n = 0;
		do begin
			repeat (8) @(posedge pclk);
			rc(idx, 8'h00, 8'h00);
			n++;
		end while ((rd & mk) != lim && n < 800);
		if ((rd & mk) != lim) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, rd & mk, lim);
		end
	endtask : poll

	// Every answer is compared with the oldest note
	always @(posedge pclk) begin
		if (presetn && pready) begin
			note = notes.pop_front();
			check({pslverr, prdata[7:0] & note.mk}, {note.er, note.ex & note.mk});
		end
	end

	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, 0, 1);
			final_report();
		end
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, run, slow, presetn} = 6'h00;
		paddr = 11'h000;
		pwdata = 32'h0;
		seed = 32'h1B7C8E59;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++) rc(rst_idx[i], rst_val[i], rst_msk[i]);
		wr(`HLC_TX_LIVE, 8'hFF);
		rc(`HLC_TX_LIVE, 8'h01, 8'h01);
		rc(`HLC_TX_LAT, 8'h01, 8'h01);
		wr(`HLC_TX_LAT, 8'h00);
		rc(`HLC_TX_LAT, 8'h01, 8'h01);
		wr(`HLC_TX_LAT, 8'h01);
		rc(`HLC_TX_LAT, 8'h00, 8'h01);
		$display("test reset_status done");
		for (int m = 0; m < 3; m++) begin
			slow <= m[0];
			wr(`HLC_RX_MAP, maps[m]);
			wr(`HLC_TX_CTL2, maps[m]);
			wr(`HLC_RX_SUP, 8'h03);
			wr(`HLC_TX_SUP, 8'h03);
			wr(`HLC_TX_MSK, m < 2 ? 8'h04 : 8'h00);
			frame[0] = 8'h7E;
			frame[1] = xs();
			frame[2] = xs();
			for (int i = 0; i < 3; i++) begin
				if (i == 2) wr(`HLC_TX_CTL1, 8'h04);
				wr(`HLC_TX_DATA, frame[i]);
			end
			rc(`HLC_TX_SPACE, 8'h3D, 8'hFF);
			run <= 1'b1;
			poll(`HLC_RX_AVAIL, 8'hFF, 8'h03);
			rc(`HLC_RX_AVAIL, 8'h03, 8'hFF);
			check({8'h00, interrupt_out_n}, {8'h00, m == 2});
			for (int i = 0; i < 3; i++) rc(`HLC_RX_DATA, frame[i], 8'hFF);
			rc(`HLC_RX_LAT, 8'h05, 8'h15);
			wr(`HLC_RX_LAT, rd);
			rc(`HLC_TX_LAT, 8'h04, 8'h04);
			repeat (2) @(posedge pclk);
			check({8'h00, interrupt_out_n}, 9'h001);
			wr(`HLC_TX_LAT, 8'h04);
			run <= 1'b0;
			$display("test frame carrier %0d done", m);
		end
		wr(`HLC_RX_MAP, 8'h40);
		wr(`HLC_TX_CTL2, 8'h40);
		for (int i = 0; i < 65; i++) wr(`HLC_TX_DATA, xs());
		rc(`HLC_TX_SPACE, 8'h00, 8'hFF);
		rc(`HLC_TX_LIVE, 8'h00, 8'h01);
		run <= 1'b1;
		poll(`HLC_TX_SPACE, 8'hFF, 8'h06);
		for (int i = 0; i < 6; i++) begin
			if (i == 5) wr(`HLC_TX_CTL1, 8'h04);
			wr(`HLC_TX_DATA, xs());
		end
		poll(`HLC_RX_AVAIL, 8'h7F, 8'h08);
		check({8'h00, rd[7]}, 9'h001);
		poll(`HLC_RX_LAT, 8'h20, 8'h20);
		rc(`HLC_RX_LAT, 8'h22, 8'h22);
		rc(`HLC_RX_AVAIL, 8'h00, 8'h7F);
		rc(`HLC_RX_DATA, 8'h00, 8'hFF);
		rc(`HLC_RX_LIVE, 8'h00, 8'h02);
		$display("test overrun done");
		final_report();
	end
endmodule : tb_hlc_link_ctrl
